// File: common/tso_link_if.sv
// Purpose: word link from the host loader to the checksum engine
// Assumes: one clock shared by both ends
// Notes: word_valid/word_ready handshake, one word per accepted edge
`timescale 1ns/100ps
interface tso_link_if;
   logic word_valid;
   logic word_ready;
   logic [31:0] word_data;
   logic tx_offload_enable;
   logic dev_idle;

   modport host (
      output word_valid,
      output word_data,
      output tx_offload_enable,
      input word_ready,
      input dev_idle
   );
   modport dev (
      input word_valid,
      input word_data,
      input tx_offload_enable,
      output word_ready,
      output dev_idle
   );
endinterface : tso_link_if

// File: common/tso_pkg.sv
// Purpose: shared constants for the transmit checksum offload pair
// Assumes: 32-bit link words, byte 0 of a packet in bits 7:0
// Notes: command word layouts are fixed by this pair of ends
package tso_pkg;
   // command word A
   localparam int unsigned CA_FIRST_SEG = 13;
   localparam int unsigned CA_LAST_SEG = 12;
   localparam int unsigned CA_BUF_LEN_HI = 10;
   // command word B
   localparam int unsigned CB_CSUM_REQ = 14;
   localparam int unsigned CB_PKT_LEN_HI = 10;
   // checksum preamble word
   localparam int unsigned PR_ZERO_SEL = 31;
   localparam int unsigned PR_INS_HI = 27;
   localparam int unsigned PR_INS_LO = 16;
   localparam int unsigned PR_START_HI = 11;
   localparam logic [11:0] PRE_BYTES = 12'h004;
   // packet store: 512 words of 4 bytes
   localparam int unsigned MEM_WORDS = 512;
   // host-side APB register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRE = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam int unsigned CTRL_EN = 0;
   localparam int unsigned CTRL_MODE = 1;
   localparam int unsigned CMD_CSUM_REQ = 16;
   localparam int unsigned CMD_LEN_HI = 10;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PRE_RST = 32'h0000_0000;
endpackage : tso_pkg

// File: rtl/tso_dev_end.sv
// Purpose: store-and-forward transmit checksum engine
// Assumes: data buffers other than a packet's last are whole words
// Notes: the packet is held in flops until its sum is known
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps

module tso_dev_end (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   tso_link_if.dev link,
   output logic mac_valid_o,
   output logic [7:0] mac_data_o,
   output logic mac_last_o,
   input wire logic mac_ready_i,
   output logic busy_o
);
   typedef enum logic [2:0] {
      ST_CMDA, ST_CMDB, ST_DATA, ST_SEND
   } tso_dst_e;

   tso_dst_e state_ff;
   logic fs_ff;
   logic pkt_open_ff;
   logic active_ff;
   logic pre_wait_ff;
   logic zsel_ff;
   logic [11:0] buf_rem_ff;
   logic [11:0] pkt_len_ff;
   logic [11:0] wr_byte_ff;
   logic [11:0] rd_byte_ff;
   logic [11:0] start_ff;
   logic [11:0] loc_ff;
   logic [27:0] acc_ff;
   logic [15:0] csum_ff;
   logic [31:0] mem_ff [tso_pkg::MEM_WORDS];
   logic mac_valid_ff;
   logic [7:0] mac_data_ff;
   logic mac_last_ff;

   logic take;
   logic [2:0] take_n;
   logic [15:0] term [4];
   logic [27:0] nxt_acc;
   logic [16:0] fold_a;
   logic [15:0] fold_b;
   logic [15:0] nxt_csum;
   logic [7:0] rd_byte;
   logic out_load;
   logic buf_done;

   // ****************************************
   // link side
   // ****************************************
   assign link.word_ready = (state_ff == ST_CMDA) || (state_ff == ST_CMDB)
      || ((state_ff == ST_DATA) && (buf_rem_ff != 12'h000));
   assign take = link.word_valid && link.word_ready;
   assign take_n = (buf_rem_ff >= 12'h004) ? 3'd4 : buf_rem_ff[2:0];
   assign link.dev_idle = (state_ff == ST_CMDA) && !pkt_open_ff
      && !mac_valid_ff;
   assign busy_o = !link.dev_idle;
   assign buf_done = (state_ff == ST_DATA) && (buf_rem_ff == 12'h000);

   // ****************************************
   // sum of each word as it arrives
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         tso_lane_term #(.LANE(12'(g))) u_lane (
            .en_i(3'(g) < take_n),
            .data_i(link.word_data[8*g +: 8]),
            .base_i(wr_byte_ff),
            .start_i(start_ff),
            .lim_i(pkt_len_ff),
            .term_o(term[g])
         );
      end
   endgenerate

   assign nxt_acc = acc_ff + 28'(term[0]) + 28'(term[1])
      + 28'(term[2]) + 28'(term[3]);
   // end-around carry; upper 12 bits padded with 5 zero bits
   assign fold_a = {1'b0, acc_ff[15:0]} + {5'h00, acc_ff[27:16]};
   assign fold_b = fold_a[15:0] + {15'h0000, fold_a[16]};

   always_comb begin
      nxt_csum = ~fold_b;
      if (zsel_ff && (nxt_csum == 16'h0000)) begin
         nxt_csum = 16'hffff;
      end
   end

   // ****************************************
   // packet control
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_CMDA;
         fs_ff <= 1'b0;
         pkt_open_ff <= 1'b0;
         active_ff <= 1'b0;
         pre_wait_ff <= 1'b0;
         buf_rem_ff <= 12'h000;
         pkt_len_ff <= 12'h000;
      end else begin
         case (state_ff)
            ST_CMDA: begin
               if (take) begin
                  fs_ff <= link.word_data[tso_pkg::CA_FIRST_SEG];
                  buf_rem_ff <= {1'b0,
                     link.word_data[tso_pkg::CA_BUF_LEN_HI:0]};
                  state_ff <= ST_CMDB;
               end
            end
            ST_CMDB: begin
               if (take) begin
                  // only the first command B of a packet counts
                  if (fs_ff) begin
                     pkt_open_ff <= 1'b1;
                     pkt_len_ff <= {1'b0,
                        link.word_data[tso_pkg::CB_PKT_LEN_HI:0]}
                        - (link.tx_offload_enable ? tso_pkg::PRE_BYTES
                           : 12'h000);
                     active_ff <= link.tx_offload_enable
                        && link.word_data[tso_pkg::CB_CSUM_REQ];
                     pre_wait_ff <= link.tx_offload_enable;
                  end
                  state_ff <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (take) begin
                  buf_rem_ff <= buf_rem_ff - 12'(take_n);
                  pre_wait_ff <= 1'b0;
               end else if (buf_done) begin
                  if (pkt_open_ff && (wr_byte_ff >= pkt_len_ff)) begin
                     pkt_open_ff <= 1'b0;
                     state_ff <= (pkt_len_ff == 12'h000) ? ST_CMDA
                        : ST_SEND;
                  end else begin
                     state_ff <= ST_CMDA;
                  end
               end
            end
            ST_SEND: begin
               if (mac_valid_ff && mac_ready_i && mac_last_ff) begin
                  state_ff <= ST_CMDA;
               end
            end
            default: state_ff <= ST_CMDA;
         endcase
      end
   end

   // ****************************************
   // preamble capture
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         start_ff <= 12'h000;
         loc_ff <= 12'h000;
         zsel_ff <= 1'b0;
      end else if (state_ff == ST_DATA && take && pre_wait_ff) begin
         start_ff <= link.word_data[tso_pkg::PR_START_HI:0];
         loc_ff <= link.word_data[tso_pkg::PR_INS_HI:tso_pkg::PR_INS_LO];
         zsel_ff <= link.word_data[tso_pkg::PR_ZERO_SEL];
      end
   end

   // ****************************************
   // packet store and running sum
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         wr_byte_ff <= 12'h000;
         acc_ff <= 28'h000_0000;
      end else if (state_ff == ST_CMDB && take && fs_ff) begin
         wr_byte_ff <= 12'h000;
         acc_ff <= 28'h000_0000;
      end else if (state_ff == ST_DATA && take && !pre_wait_ff) begin
         wr_byte_ff <= wr_byte_ff + 12'(take_n);
         acc_ff <= nxt_acc;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (state_ff == ST_DATA && take && !pre_wait_ff) begin
         mem_ff[wr_byte_ff[10:2]] <= link.word_data;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         csum_ff <= 16'h0000;
      end else if (buf_done) begin
         csum_ff <= nxt_csum;
      end
   end

   // ****************************************
   // byte stream to the transmitter
   // ****************************************
   always_comb begin
      rd_byte = mem_ff[rd_byte_ff[10:2]][{rd_byte_ff[1:0], 3'b000} +: 8];
      // two bytes replaced, low byte first
      if (active_ff && (rd_byte_ff == loc_ff)) begin
         rd_byte = csum_ff[7:0];
      end else if (active_ff && (rd_byte_ff == loc_ff + 12'h001)) begin
         rd_byte = csum_ff[15:8];
      end
   end

   assign out_load = (state_ff == ST_SEND) && (rd_byte_ff < pkt_len_ff)
      && (!mac_valid_ff || mac_ready_i);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_byte_ff <= 12'h000;
         mac_valid_ff <= 1'b0;
         mac_data_ff <= 8'h00;
         mac_last_ff <= 1'b0;
      end else if (out_load) begin
         rd_byte_ff <= rd_byte_ff + 12'h001;
         mac_valid_ff <= 1'b1;
         mac_data_ff <= rd_byte;
         mac_last_ff <= (rd_byte_ff == pkt_len_ff - 12'h001);
      end else begin
         if (mac_ready_i) begin
            mac_valid_ff <= 1'b0;
         end
         if (state_ff != ST_SEND) begin
            rd_byte_ff <= 12'h000;
         end
      end
   end

   assign mac_valid_o = mac_valid_ff;
   assign mac_data_o = mac_data_ff;
   assign mac_last_o = mac_last_ff;
endmodule : tso_dev_end

// File: rtl/tso_host_end.sv
// Purpose: host loader, turns APB orders into link words
// Assumes: one packet per order, frame data written word by word
// Notes: data writes stall pready until the link has taken the previous word
`timescale 1ns/100ps
module tso_host_end (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   tso_link_if.host link
);
   typedef enum logic [2:0] {
      HS_IDLE, HS_A1, HS_B1, HS_PRE, HS_A2, HS_B2, HS_DATA
   } tso_hst_e;

   tso_hst_e state_ff;
   logic [31:0] ctrl_ff;
   logic [31:0] pre_ff;
   logic [10:0] len_ff;
   logic ck_ff;
   logic [9:0] dw_rem_ff;
   logic dvalid_ff;
   logic [31:0] dword_ff;

   logic access;
   logic en;
   logic quiet;
   logic is_data;
   logic wr_ok;
   logic sent;
   logic [10:0] len_b;

   assign access = psel_i && penable_i;
   assign en = ctrl_ff[tso_pkg::CTRL_EN];
   assign quiet = (state_ff == HS_IDLE) && link.dev_idle;
   assign is_data = pwrite_i && (paddr_i == tso_pkg::OFS_DATA);
   assign sent = link.word_valid && link.word_ready;
   assign len_b = len_ff + (en ? 11'(tso_pkg::PRE_BYTES) : 11'h000);

   // ****************************************
   // APB slave
   // ****************************************
   assign pready_o = !(access && is_data && (state_ff != HS_IDLE)
      && ((state_ff != HS_DATA) || dvalid_ff));

   always_comb begin
      pslverr_o = 1'b0;
      if (access && pwrite_i) begin
         // enable and mode frozen unless flushed
         if (paddr_i == tso_pkg::OFS_CTRL) begin
            pslverr_o = !quiet;
         end else if (paddr_i == tso_pkg::OFS_PRE
            || paddr_i == tso_pkg::OFS_CMD) begin
            pslverr_o = (state_ff != HS_IDLE);
         end else if (paddr_i == tso_pkg::OFS_DATA) begin
            pslverr_o = (state_ff == HS_IDLE);
         end else begin
            pslverr_o = 1'b1;
         end
      end else if (access) begin
         pslverr_o = !(paddr_i == tso_pkg::OFS_CTRL
            || paddr_i == tso_pkg::OFS_PRE || paddr_i == tso_pkg::OFS_CMD
            || paddr_i == tso_pkg::OFS_STAT);
      end
   end

   assign wr_ok = access && pwrite_i && pready_o && !pslverr_o;

   always_comb begin
      prdata_o = 32'h0000_0000;
      if (paddr_i == tso_pkg::OFS_CTRL) begin
         prdata_o = ctrl_ff;
      end else if (paddr_i == tso_pkg::OFS_PRE) begin
         prdata_o = pre_ff;
      end else if (paddr_i == tso_pkg::OFS_CMD) begin
         prdata_o = {15'h0000, ck_ff, 5'h00, len_ff};
      end else if (paddr_i == tso_pkg::OFS_STAT) begin
         prdata_o = {30'h0000_0000, link.dev_idle, state_ff != HS_IDLE};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= tso_pkg::CTRL_RST;
         pre_ff <= tso_pkg::PRE_RST;
      end else if (wr_ok && paddr_i == tso_pkg::OFS_CTRL) begin
         ctrl_ff <= pwdata_i & 32'h0000_0003;
      end else if (wr_ok && paddr_i == tso_pkg::OFS_PRE) begin
         pre_ff <= pwdata_i & 32'h8fff_0fff;
      end
   end

   // ****************************************
   // word sequencer
   // ****************************************
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_ff <= HS_IDLE;
         len_ff <= 11'h000;
         ck_ff <= 1'b0;
         dw_rem_ff <= 10'h000;
      end else begin
         case (state_ff)
            HS_IDLE: begin
               if (wr_ok && paddr_i == tso_pkg::OFS_CMD) begin
                  len_ff <= pwdata_i[tso_pkg::CMD_LEN_HI:0];
                  ck_ff <= pwdata_i[tso_pkg::CMD_CSUM_REQ];
                  dw_rem_ff <= 10'((pwdata_i[10:0] + 11'h003) >> 2);
                  state_ff <= en ? HS_A1 : HS_A2;
               end
            end
            HS_A1: if (sent) state_ff <= HS_B1;
            HS_B1: if (sent) state_ff <= HS_PRE;
            HS_PRE: if (sent) state_ff <= HS_A2;
            HS_A2: if (sent) state_ff <= HS_B2;
            HS_B2: begin
               if (sent) begin
                  state_ff <= (dw_rem_ff == 10'h000) ? HS_IDLE : HS_DATA;
               end
            end
            HS_DATA: begin
               if (sent) begin
                  dw_rem_ff <= dw_rem_ff - 10'h001;
                  if (dw_rem_ff == 10'h001) begin
                     state_ff <= HS_IDLE;
                  end
               end
            end
            default: state_ff <= HS_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         dvalid_ff <= 1'b0;
         dword_ff <= 32'h0000_0000;
      end else if (wr_ok && is_data) begin
         dvalid_ff <= 1'b1;
         dword_ff <= pwdata_i;
      end else if (sent && state_ff == HS_DATA) begin
         dvalid_ff <= 1'b0;
      end
   end

   assign link.tx_offload_enable = en;
   assign link.word_valid = (state_ff == HS_DATA) ? dvalid_ff
      : (state_ff != HS_IDLE);

   always_comb begin
      link.word_data = dword_ff;
      case (state_ff)
         // preamble alone in a one-word buffer
         HS_A1: link.word_data = 32'h0000_2004;
         HS_B1, HS_B2: link.word_data = {17'h0_0000, ck_ff, 3'b000, len_b};
         HS_PRE: link.word_data = pre_ff;
         HS_A2: link.word_data = {18'h0_0000, !en, 2'b10, len_ff};
         default: link.word_data = dword_ff;
      endcase
   end
endmodule : tso_host_end

// File: rtl/tso_lane_term.sv
// Purpose: one byte lane's contribution to the 16-bit sum
// Assumes: offsets are packet byte offsets
// Notes: pairs bytes from the start offset, earlier byte low
`timescale 1ns/100ps
module tso_lane_term #(
   parameter logic [11:0] LANE = 12'h000
) (
   input wire logic en_i,
   input wire logic [7:0] data_i,
   input wire logic [11:0] base_i,
   input wire logic [11:0] start_i,
   input wire logic [11:0] lim_i,
   output logic [15:0] term_o
);
   logic [11:0] off;
   logic [11:0] rel;

   assign off = base_i + LANE;
   assign rel = off - start_i;

   always_comb begin
      term_o = 16'h0000;
      if (en_i && (off >= start_i) && (off < lim_i)) begin
         term_o = rel[0] ? {data_i, 8'h00} : {8'h00, data_i};
      end
   end
endmodule : tso_lane_term

// File: verif/tso_asserts.sv
// Purpose: link and byte stream checks for the offload pair
// Assumes: one clock, reset synchronous and active low
// Notes: watches the joining interface and the device output
`timescale 1ns/100ps
module tso_asserts (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic word_valid,
   input wire logic word_ready,
   input wire logic [31:0] word_data,
   input wire logic tx_offload_enable,
   input wire logic dev_idle,
   input wire logic mac_valid_o,
   input wire logic [7:0] mac_data_o,
   input wire logic mac_last_o,
   input wire logic mac_ready_i,
   input wire logic busy_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ****************************
   // packet steps
   // ****************************
   sequence s_first_cmd;
      word_valid && word_ready && dev_idle
         && word_data[tso_pkg::CA_FIRST_SEG];
   endsequence
   sequence s_last_out;
      mac_valid_o && mac_ready_i && mac_last_o;
   endsequence
   a_word_held: assert property (
      word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("link word changed before taken");
   a_open_packet: assert property (
      s_first_cmd |=> !dev_idle && word_ready)
      else $error("first command did not open a packet");
   a_enable_steady: assert property (
      !dev_idle |=> $stable(tx_offload_enable))
      else $error("enable changed while packet open");
   a_idle_ready: assert property (
      dev_idle |-> word_ready && !mac_valid_o)
      else $error("idle device not waiting for command");
   a_send_closed: assert property (
      mac_valid_o |-> !word_ready && busy_o)
      else $error("link taken while packet sending");
   a_byte_held: assert property (
      mac_valid_o && !mac_ready_i |=> mac_valid_o && $stable(mac_data_o)
         && $stable(mac_last_o))
      else $error("output byte changed while stalled");
   a_end_idle: assert property (
      s_last_out |=> !mac_valid_o ##[0:2] dev_idle)
      else $error("device not idle after last byte");
   // whole packet is stored first, so nothing leaves right away
   a_no_early: assert property (
      s_first_cmd |=> !mac_valid_o [*3])
      else $error("output began before packet stored");
endmodule : tso_asserts

// File: verif/tx_checksum_offload_bench.sv
// Purpose: end to end bench, APB orders in, bytes out
// Assumes: sink stalls at random, packets of 40 to 64 bytes
// Notes: expected bytes come from a behavioural sum model
`timescale 1ns/100ps
module tx_checksum_offload_bench;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, mac_valid_o, mac_last_o, busy_o;
   logic [7:0] mac_data_o;
   logic mac_ready_i = 1'b0;
   logic [31:0] rs = 32'h0001_3f9d;
   logic [31:0] ds = 32'h0001_3f9d;
   logic [31:0] rd_v;
   logic er_v;
   logic [7:0] got[$];
   int last_at = 0;
   int errors = 0;
   int checks_done = 0;
   tso_link_if link ();
   tso_host_end tso_host_end_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .link(link));
   tso_dev_end tso_dev_end_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .link(link), .mac_valid_o(mac_valid_o),
      .mac_data_o(mac_data_o), .mac_last_o(mac_last_o),
      .mac_ready_i(mac_ready_i), .busy_o(busy_o));
   tso_asserts tso_asserts_inst (.ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i), .word_valid(link.word_valid),
      .word_ready(link.word_ready), .word_data(link.word_data),
      .tx_offload_enable(link.tx_offload_enable),
      .dev_idle(link.dev_idle), .mac_valid_o(mac_valid_o),
      .mac_data_o(mac_data_o), .mac_last_o(mac_last_o),
      .mac_ready_i(mac_ready_i), .busy_o(busy_o));
   always #4 ref_clk_i = ~ref_clk_i;
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // random sink stalls exercise the held output byte
   always @(posedge ref_clk_i) begin
      rs <= xs(rs);
      mac_ready_i <= (rs[1:0] != 2'b00);
   end
   always @(posedge ref_clk_i) begin
      if (mac_valid_o && mac_ready_i) begin
         got.push_back(mac_data_o);
         if (mac_last_o) last_at = got.size();
      end
   end
   // ****************************
   // bus and compare tasks
   // ****************************
   task automatic chk(input string nm, input logic [31:0] s,
         input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         errors++;
         $display("wrong value %s exp %h got %h", nm, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      // pready is read before this edge's own updates land
      do begin
         @(posedge ref_clk_i);
      end while (pready_o !== 1'b1);
      rd_v = prdata_o;
      er_v = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask : apb
   task automatic pkt(input string nm, input logic [1:0] ctl,
         input logic ck, input logic zs, input int st, input int ins,
         input int len, input bit ff);
      logic [7:0] b[$];
      logic [31:0] w;
      logic [15:0] cs;
      int sum;
      got = {};
      last_at = 0;
      for (int i = 0; i < len; i++) begin
         ds = xs(ds);
         b.push_back((ff && i >= st) ? 8'hff : ds[7:0]);
      end
      apb(1'b1, tso_pkg::OFS_CTRL, {30'h0, ctl});
      chk("ctrl err", er_v, 0);
      apb(1'b1, tso_pkg::OFS_PRE, {zs, 3'h0, ins[11:0], 4'h0, st[11:0]});
      apb(1'b0, tso_pkg::OFS_PRE, 32'h0000_0000);
      chk("pre read", rd_v, {zs, 3'h0, ins[11:0], 4'h0, st[11:0]});
      apb(1'b1, tso_pkg::OFS_CMD, {15'h0, ck, 5'h0, len[10:0]});
      chk("cmd err", er_v, 0);
      for (int i = 0; i < len; i += 4) begin
         w = 32'h0000_0000;
         for (int k = 0; k < 4; k++)
            if (i + k < len) w[8*k +: 8] = b[i+k];
         apb(1'b1, tso_pkg::OFS_DATA, w);
      end
      if (ctl[0] && ck) begin
         sum = 0;
         // earlier byte low, odd tail padded with zero
         for (int i = st; i < len; i += 2)
            sum += b[i] + ((i + 1 < len) ? (int'(b[i+1]) << 8) : 0);
         while (sum >> 16) sum = (sum & 32'h0000_ffff) + (sum >> 16);
         cs = ~sum[15:0];
         if (zs && cs == 16'h0000) cs = 16'hffff;
         b[ins] = cs[7:0];
         b[ins+1] = cs[15:8];
      end
      // a hang is left to the watchdog
      while (last_at == 0 || busy_o !== 1'b0) begin
         @(posedge ref_clk_i);
      end
      chk("frame length", last_at, len);
      for (int i = 0; i < len; i++)
         chk("frame byte", got[i], b[i]);
      $display("test %s done", nm);
   endtask : pkt
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      errors++;
      summarize();
   end
   // ****************************
   // main sequence
   // ****************************
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      apb(1'b0, tso_pkg::OFS_CTRL, 32'h0000_0000);
      chk("ctrl reset", rd_v, tso_pkg::CTRL_RST);
      apb(1'b0, tso_pkg::OFS_STAT, 32'h0000_0000);
      chk("status idle", rd_v, 32'h0000_0002);
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk("unmapped err", er_v, 1);
      apb(1'b1, tso_pkg::OFS_DATA, 32'h1234_5678);
      chk("stray data err", er_v, 1);
      $display("test registers done");
      pkt("sum even", 2'b01, 1'b1, 1'b0, 14, 24, 60, 0);
      pkt("sum odd", 2'b11, 1'b1, 1'b1, 15, 40, 62, 0);
      pkt("no request", 2'b01, 1'b0, 1'b0, 14, 24, 40, 0);
      pkt("disabled", 2'b00, 1'b1, 1'b0, 14, 24, 40, 0);
      pkt("zero ones", 2'b01, 1'b1, 1'b1, 20, 16, 50, 1);
      pkt("zero kept", 2'b01, 1'b1, 1'b0, 20, 16, 50, 1);
      pkt("fold partial", 2'b01, 1'b1, 1'b0, 14, 30, 64, 0);
      summarize();
   end
endmodule : tx_checksum_offload_bench
